// ---- core/dofd_cfg.svh ----
// Purpose: offsets, field positions, limits and reset values
// Assumes: classic 32-bit bus, byte addresses, aligned words
// Notes:   field positions are part-select bounds
`ifndef DOFD_CFG_SVH
`define DOFD_CFG_SVH
// register byte offsets
`define DOFD_ADR_W      8
`define DOFD_A_FIELDS0  8'h00
`define DOFD_A_FIELDS1  8'h04
`define DOFD_A_OPERAND  8'h08
`define DOFD_A_COMMAND  8'h0C
`define DOFD_A_WORDIN   8'h10
`define DOFD_A_DECODE   8'h14
`define DOFD_A_STATUS   8'h18
`define DOFD_A_RESULT   8'h1C
`define DOFD_A_ACCA_LO  8'h20
`define DOFD_A_ACCA_HI  8'h24
`define DOFD_A_ACCB_LO  8'h28
`define DOFD_A_ACCB_HI  8'h2C
`define DOFD_A_AUX      8'h30
`define DOFD_A_PAIR_LO  8'h34
`define DOFD_A_PAIR_HI  8'h38
// operand field register 0
`define DOFD_F0_XPF     3:0
`define DOFD_F0_YPF     7:4
`define DOFD_F0_XDST    9:8
`define DOFD_F0_YDST    11:10
`define DOFD_F0_MPAIR   14:12
`define DOFD_F0_SQUARE  15
`define DOFD_F0_SQREG   17:16
`define DOFD_F0_AWB     19:18
`define DOFD_F0_SIZE    21:20
`define DOFD_F0_SHADOW  22
`define DOFD_F0_ACCSEL  23
`define DOFD_F0_FDEST   24
`define DOFD_F0_DMODE   27:25
`define DOFD_F0_BITPOS  31:28
// operand field register 1
`define DOFD_F1_FADDR   15:0
`define DOFD_F1_LIT     25:16
`define DOFD_F1_MASK    32'h03FF_FFFF
// command and word-in bits
`define DOFD_CMD_ALU    0
`define DOFD_CMD_ACC    1
`define DOFD_WI_WORD    23:0
`define DOFD_WI_HI8     23:16
`define DOFD_WI_FIRST   24
// status bits
`define DOFD_ST_AFLG    4:0
`define DOFD_ST_DFLG    8:5
`define DOFD_ST_PF      12:9
`define DOFD_ST_AWB     14:13
`define DOFD_ST_ERR     21:16
`define DOFD_ST_SWERR   22
`define DOFD_ST_NOP     23
`define DOFD_ST_SHADOW  24
`define DOFD_ST_PEND    25
// arithmetic flag order inside the flag field
`define DOFD_FL_C       0
`define DOFD_FL_DC      1
`define DOFD_FL_N       2
`define DOFD_FL_OV      3
`define DOFD_FL_Z       4
// working register numbers and limits
`define DOFD_W0         4'h0
`define DOFD_W4         4'h4
`define DOFD_W5         4'h5
`define DOFD_W6         4'h6
`define DOFD_W7         4'h7
`define DOFD_W8         4'h8
`define DOFD_W10        4'hA
`define DOFD_W12        4'hC
`define DOFD_W13        4'hD
`define DOFD_AWB_INC    4'h2
`define DOFD_PF_STEP    4'h2
`define DOFD_PF_PER_PTR 4'h7
`define DOFD_PF_IDX     4'hE
`define DOFD_PF_NONE    4'hF
`define DOFD_MP_W5GRP   3'h3
`define DOFD_MP_W6GRP   3'h5
`define DOFD_FADDR_MAX  16'h1FFF
`define DOFD_LIT_BYTE   10'h0FF
`define DOFD_RST_WORD   32'h0000_0000
`endif

// ---- core/dofd_pkg.sv ----
// Purpose: shared types of the operand field decoder
// Assumes: constants live in dofd_cfg.svh
// Notes:   state of dofd_top and of dofd_acc_unit is one packed struct each
package dofd_pkg;
    // operand size suffix
    typedef enum logic [1:0] {
        DOFD_SZ_WORD  = 2'b00,
        DOFD_SZ_BYTE  = 2'b01,
        DOFD_SZ_DWORD = 2'b10,
        DOFD_SZ_BAD   = 2'b11
    } dofd_size_e;
    // write-back target choice
    typedef enum logic [1:0] {
        DOFD_AWB_NONE = 2'b00,
        DOFD_AWB_DIR  = 2'b01,
        DOFD_AWB_POST = 2'b10,
        DOFD_AWB_BAD  = 2'b11
    } dofd_awb_e;
    // top-level state
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [31:0] f0;
        logic [31:0] f1;
        logic [31:0] opnd;
        logic [15:0] res;
        logic [4:0]  aflg;
        logic        pend;
        logic [23:0] first;
        logic [47:0] pair;
        logic        nop;
        logic        swerr;
    } dofd_core_s;
    // accumulator state
    typedef struct packed {
        logic [1:0][39:0] acc;
        logic [1:0]       wrap;
        logic [1:0]       clip;
    } dofd_acc_s;
endpackage : dofd_pkg

// ---- core/dofd_pf_dec.sv ----
// Purpose: decode one prefetch address code into pointer and step
// Assumes: codes 0..6 first pointer, 7..13 second, 14 indexed, 15 none
// Notes:   purely combinational
`include "dofd_cfg.svh"
module dofd_pf_dec #(
    parameter logic [3:0] BASE = `DOFD_W8
) (
    // code in
    input  wire logic [3:0] code_i,
    // decoded operand
    output logic            en_o,
    output logic            idx_o,
    output logic [3:0]      ptr_o,
    output logic [3:0]      off_o
);
    logic [3:0] k;  // step index within one pointer

    // step table: +6 +4 +2 0 -6 -4 -2
    always_comb begin
        k     = (code_i < `DOFD_PF_PER_PTR) ? code_i : code_i - `DOFD_PF_PER_PTR;
        en_o  = (code_i != `DOFD_PF_NONE);
        idx_o = (code_i == `DOFD_PF_IDX);
        ptr_o = (code_i < `DOFD_PF_PER_PTR) ? BASE : BASE + 4'h1;
        if (idx_o || !en_o || k == 4'h3) begin
            off_o = 4'h0;
        end else if (k < 4'h3) begin
            off_o = 4'(`DOFD_PF_STEP * (4'h3 - k));
        end else begin
            off_o = 4'(4'h0 - `DOFD_PF_STEP * (4'h7 - k));
        end
    end
endmodule : dofd_pf_dec

// ---- core/dofd_acc_unit.sv ----
// Purpose: two 40-bit accumulators with wrap and clip flags
// Assumes: one add of a signed word per go pulse
// Notes:   clipping keeps the value at the 40-bit extreme
`include "dofd_cfg.svh"
module dofd_acc_unit (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // operation
    input  wire logic             go_i,
    input  wire logic             sel_i,
    input  wire logic [15:0]      val_i,
    // state out
    output logic [1:0][39:0]      acc_o,
    output logic [1:0]            wrap_o,
    output logic [1:0]            clip_o
);
    dofd_pkg::dofd_acc_s s;       // registered state
    dofd_pkg::dofd_acc_s next_s;  // next state
    logic [1:0][40:0]    sum;     // one guard bit above the accumulator
    logic [1:0][39:0]    nval;    // clipped value
    logic [1:0]          clp;     // 40-bit overflow
    logic [1:0]          wrp;     // ran into the guard bits

    // per accumulator adder and clipping
    for (genvar gi = 0; gi < 2; gi++) begin : g_acc
        assign sum[gi]  = {s.acc[gi][39], s.acc[gi]} + {{25{val_i[15]}}, val_i};
        assign clp[gi]  = sum[gi][40] ^ sum[gi][39];
        assign nval[gi] = clp[gi] ? {sum[gi][40], {39{~sum[gi][40]}}} : sum[gi][39:0];
        // guard bits not a sign copy means the 32-bit range was left
        assign wrp[gi]  = !(&nval[gi][39:31] || ~|nval[gi][39:31]);
    end

    // only the selected accumulator moves
    always_comb begin
        next_s = s;
        if (go_i) begin
            next_s.acc[sel_i]  = nval[sel_i];   // RL14
            next_s.wrap[sel_i] = wrp[sel_i];    // RL13
            next_s.clip[sel_i] = clp[sel_i];    // RL13
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign acc_o  = s.acc;
    assign wrap_o = s.wrap;
    assign clip_o = s.clip;
endmodule : dofd_acc_unit

// ---- core/dofd_top.sv ----
// Purpose: operand field decoder and checker with flag and accumulator state
// Assumes: classic bus slave, one clock, synchronous active-low reset
// Notes:   field checks are levels that follow the field registers
// Function
// [RL1] x prefetch only from W8, W9 forms
// [RL2] y prefetch only from W10, W11 forms
// [RL3] prefetch destinations limited to W4..W7
// [RL4] six distinct multiply pairs only
// [RL5] square uses W4..W7 times itself
// [RL6] write-back to W13 or [W13]+=2
// [RL7] W0 implicit file instruction operand
// [RL8] file addresses reach up to 0x1FFF
// [RL9] constant up to 255 in byte mode
// [RL10] program address constant has zero lsb; no field holds it and nothing here checks it
// [RL11] bit field picks bit 0..15
// [RL12] five arithmetic flags follow results
// [RL13] wrap and clip flags per accumulator
// [RL14] two accumulators, one-bit select
// [RL15] direct, indirect, modified and offset forms
// [RL16] byte, word default, double word, shadow
// [RL17] 48-bit pairs; lone second word no-op
`include "dofd_cfg.svh"
module dofd_top (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    // classic bus slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [`DOFD_ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o
);
    ////////////////////////////////////////////////////////////////////////
    dofd_pkg::dofd_core_s s;        // registered state
    dofd_pkg::dofd_core_s next_s;   // next state
    dofd_pkg::dofd_size_e size;     // size suffix
    dofd_pkg::dofd_awb_e  result_store_back_target;      // write-back choice
    logic                 req;      // open bus cycle
    logic                 wr_ok;    // write commits at the ack edge
    logic [7:0]           adr;      // word aligned address
    logic [31:0]          wmask;    // byte lanes
    logic [31:0]          cmd;      // command pulse bits
    logic [31:0]          rd;       // read mux
    logic [31:0]          status;   // status word
    logic [31:0]          decode;   // decoded registers
    logic [31:0]          aux;      // bit mask and targets
    logic [1:0][3:0]      pf_code;  // prefetch codes
    logic [1:0]           pf_en;    // prefetch active
    logic [1:0]           pf_idx;   // indexed by W12
    logic [1:0][3:0]      pf_ptr;   // pointer register
    logic [1:0][3:0]      pf_off;   // signed post step
    logic [3:0]           xdst;     // x data destination
    logic [3:0]           ydst;     // y data destination
    logic [2:0]           mc;       // multiply pair code
    logic [3:0]           mul_m;    // multiplicand
    logic [3:0]           mul_n;    // multiplier
    logic [5:0]           err;      // field errors
    logic                 pair_bad; // pair code names no pair
    logic [3:0]           fdst;     // file instruction register
    logic [15:0]          bit_mask; // selected bit
    logic [8:0]           sb;       // byte sum
    logic [16:0]          sw;       // word sum
    logic [4:0]           nib;      // low nibble sum
    logic                 acc_go;   // accumulator add
    logic [1:0][39:0]     acc;      // accumulators
    logic [1:0]           acc_wrap; // wrap flags
    logic [1:0]           acc_clip; // clip flags

    ////////////////////////////////////////////////////////////////////////
    // prefetch address decoders, x then y
    assign pf_code[0] = s.f0[`DOFD_F0_XPF];
    assign pf_code[1] = s.f0[`DOFD_F0_YPF];
    for (genvar gi = 0; gi < 2; gi++) begin : g_pf
        dofd_pf_dec #(
            .BASE (gi == 0 ? `DOFD_W8 : `DOFD_W10)  // RL1 RL2
        ) u_pf (
            .code_i (pf_code[gi]),
            .en_o   (pf_en[gi]),
            .idx_o  (pf_idx[gi]),
            .ptr_o  (pf_ptr[gi]),
            .off_o  (pf_off[gi])
        );
    end

    // destinations are W4 plus a two-bit field
    assign xdst = `DOFD_W4 + {2'b00, s.f0[`DOFD_F0_XDST]};  // RL3
    assign ydst = `DOFD_W4 + {2'b00, s.f0[`DOFD_F0_YDST]};  // RL3

    // multiply pair and square table
    always_comb begin
        mc     = s.f0[`DOFD_F0_MPAIR];
        pair_bad = 1'b0;
        if (s.f0[`DOFD_F0_SQUARE]) begin
            mul_m = `DOFD_W4 + {2'b00, s.f0[`DOFD_F0_SQREG]};  // RL5
            mul_n = mul_m;                                       // RL5
        end else if (mc < `DOFD_MP_W5GRP) begin
            mul_m = `DOFD_W4;                                    // RL4
            mul_n = `DOFD_W5 + {1'b0, mc};
        end else if (mc < `DOFD_MP_W6GRP) begin
            mul_m = `DOFD_W5;                                    // RL4
            mul_n = `DOFD_W6 + {1'b0, mc - `DOFD_MP_W5GRP};
        end else begin
            mul_m = `DOFD_W6;                                    // RL4
            mul_n = `DOFD_W7;
            pair_bad = (mc != `DOFD_MP_W6GRP);  // codes 6 and 7 name no pair
        end
    end

    // remaining field checks
    assign size     = dofd_pkg::dofd_size_e'(s.f0[`DOFD_F0_SIZE]);
    assign result_store_back_target      = dofd_pkg::dofd_awb_e'(s.f0[`DOFD_F0_AWB]);
    assign err[0]   = pair_bad;                                           // RL4
    assign err[1]   = (result_store_back_target == dofd_pkg::DOFD_AWB_BAD);                    // RL6
    assign err[2]   = (s.f1[`DOFD_F1_FADDR] > `DOFD_FADDR_MAX);           // RL8
    assign err[3]   = (size == dofd_pkg::DOFD_SZ_BYTE)
                      && (s.f1[`DOFD_F1_LIT] > `DOFD_LIT_BYTE);           // RL9
    assign err[4]   = (size == dofd_pkg::DOFD_SZ_BAD);                    // RL16
    assign err[5]   = (s.f0[`DOFD_F0_DMODE] == 3'h7);  // code 6 is [Wns+Wb] RL15
    assign fdst     = s.f0[`DOFD_F0_FDEST] ? `DOFD_W0 : 4'hF;             // RL7
    assign bit_mask = 16'h0001 << s.f0[`DOFD_F0_BITPOS];                  // RL11

    // read-only words
    assign decode = {mul_n, mul_m, ydst, xdst, pf_off[1], pf_ptr[1], pf_off[0], pf_ptr[0]};
    assign aux    = {4'h0, fdst, result_store_back_target == dofd_pkg::DOFD_AWB_POST ? `DOFD_AWB_INC : 4'h0,
                     result_store_back_target == dofd_pkg::DOFD_AWB_NONE ? 4'h0 : `DOFD_W13, bit_mask}; // RL6
    always_comb begin
        status                 = `DOFD_RST_WORD;
        status[`DOFD_ST_AFLG]  = s.aflg;
        status[`DOFD_ST_DFLG]  = {acc_clip, acc_wrap};
        status[`DOFD_ST_PF]    = {pf_idx[1], pf_en[1], pf_idx[0], pf_en[0]};
        status[`DOFD_ST_AWB]   = s.f0[`DOFD_F0_AWB];
        status[`DOFD_ST_ERR]   = err;
        status[`DOFD_ST_SWERR] = s.swerr;
        status[`DOFD_ST_NOP]   = s.nop;
        status[`DOFD_ST_SHADOW] = s.f0[`DOFD_F0_SHADOW];  // RL16
        status[`DOFD_ST_PEND]  = s.pend;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus decode; unmapped reads return zero, unmapped writes are dropped
    assign req   = wb_cyc_i & wb_stb_i;
    assign wr_ok = req & s.ack & wb_we_i;
    assign adr   = {wb_adr_i[7:2], 2'b00};
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cmd   = (wr_ok && adr == `DOFD_A_COMMAND) ? (wb_dat_i & wmask) : `DOFD_RST_WORD;
    assign acc_go = cmd[`DOFD_CMD_ACC];

    // read mux
    always_comb begin
        unique case (adr)
            `DOFD_A_FIELDS0: rd = s.f0;
            `DOFD_A_FIELDS1: rd = s.f1;
            `DOFD_A_OPERAND: rd = s.opnd;
            `DOFD_A_DECODE:  rd = decode;
            `DOFD_A_STATUS:  rd = status;
            `DOFD_A_RESULT:  rd = {16'h0000, s.res};
            `DOFD_A_ACCA_LO: rd = acc[0][31:0];
            `DOFD_A_ACCA_HI: rd = {24'h00_0000, acc[0][39:32]};
            `DOFD_A_ACCB_LO: rd = acc[1][31:0];
            `DOFD_A_ACCB_HI: rd = {24'h00_0000, acc[1][39:32]};
            `DOFD_A_AUX:     rd = aux;
            `DOFD_A_PAIR_LO: rd = s.pair[31:0];
            `DOFD_A_PAIR_HI: rd = {16'h0000, s.pair[47:32]};
            default:         rd = `DOFD_RST_WORD;
        endcase
    end

    // adder for the flag-setting add
    assign sb  = {1'b0, s.opnd[7:0]} + {1'b0, s.opnd[23:16]};
    assign sw  = {1'b0, s.opnd[15:0]} + {1'b0, s.opnd[31:16]};
    assign nib = {1'b0, s.opnd[3:0]} + {1'b0, s.opnd[19:16]};

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s     = s;
        next_s.ack = req & ~s.ack;  // one ack per request
        if (req & ~s.ack) begin
            next_s.rdata = rd;
        end
        if (wr_ok) begin
            unique case (adr)
                `DOFD_A_FIELDS0: next_s.f0 = (s.f0 & ~wmask) | (wb_dat_i & wmask);
                `DOFD_A_FIELDS1: next_s.f1 = ((s.f1 & ~wmask) | (wb_dat_i & wmask))
                                             & `DOFD_F1_MASK;
                `DOFD_A_OPERAND: next_s.opnd = (s.opnd & ~wmask) | (wb_dat_i & wmask);
                default: ;
            endcase
        end
        // flag-setting add; a bad size suffix leaves the flags alone
        if (cmd[`DOFD_CMD_ALU] && size != dofd_pkg::DOFD_SZ_BAD) begin
            next_s.aflg[`DOFD_FL_DC] = nib[4];                                     // RL12
            if (size == dofd_pkg::DOFD_SZ_BYTE) begin
                next_s.res                = {8'h00, sb[7:0]};
                next_s.aflg[`DOFD_FL_C]   = sb[8];                                 // RL12
                next_s.aflg[`DOFD_FL_N]   = sb[7];
                next_s.aflg[`DOFD_FL_OV]  = (s.opnd[7] == s.opnd[23]) && (sb[7] != s.opnd[7]);
                next_s.aflg[`DOFD_FL_Z]   = (sb[7:0] == 8'h00);
            end else begin
                next_s.res                = sw[15:0];
                next_s.aflg[`DOFD_FL_C]   = sw[16];                                // RL12
                next_s.aflg[`DOFD_FL_N]   = sw[15];
                next_s.aflg[`DOFD_FL_OV]  = (s.opnd[15] == s.opnd[31]) && (sw[15] != s.opnd[15]);
                next_s.aflg[`DOFD_FL_Z]   = (sw[15:0] == 16'h0000);
            end
        end
        // instruction words; a second word must carry a zero top byte
        if (wr_ok && adr == `DOFD_A_WORDIN && (&wb_sel_i[2:0])) begin
            if (s.pend) begin
                next_s.pair  = {s.first, wb_dat_i[`DOFD_WI_WORD]};                 // RL17
                next_s.swerr = (wb_dat_i[`DOFD_WI_HI8] != 8'h00);                  // RL17
                next_s.pend  = 1'b0;
                next_s.nop   = 1'b0;
            end else if (wb_dat_i[`DOFD_WI_FIRST] && wb_sel_i[3]) begin
                next_s.first = wb_dat_i[`DOFD_WI_WORD];
                next_s.pend  = 1'b1;
                next_s.swerr = 1'b0;
                next_s.nop   = 1'b0;
            end else begin
                next_s.nop   = (wb_dat_i[`DOFD_WI_HI8] == 8'h00);  // lone second word RL17
                next_s.swerr = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // accumulators
    dofd_acc_unit u_acc (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .go_i     (acc_go),
        .sel_i    (s.f0[`DOFD_F0_ACCSEL]),  // RL14
        .val_i    (s.opnd[15:0]),
        .acc_o    (acc),
        .wrap_o   (acc_wrap),
        .clip_o   (acc_clip)
    );

    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_x_prefetch_ptr: assert property ( // RL1
        (pf_code[0] == `DOFD_PF_IDX |-> pf_idx[0] && pf_ptr[0] == `DOFD_W8 + 4'h1)
        and (pf_code[0] < `DOFD_PF_PER_PTR |-> pf_ptr[0] == `DOFD_W8))
        else $error("x prefetch pointer wrong");
    a_y_prefetch_ptr: assert property ( // RL2
        pf_en[1] |-> pf_ptr[1] == `DOFD_W10 + {3'h0, pf_code[1] >= `DOFD_PF_PER_PTR})
        else $error("y prefetch pointer wrong");
    a_dst_window: assert property ( // RL3
        xdst[3:2] == 2'b01 && ydst[3:2] == 2'b01)
        else $error("prefetch destination outside W4..W7");
    a_mul_pair_ok: assert property ( // RL4
        !s.f0[`DOFD_F0_SQUARE] |-> (err[0] == (mc > `DOFD_MP_W6GRP))
        && mul_m < mul_n && mul_m >= `DOFD_W4 && mul_n <= `DOFD_W7)
        else $error("multiply pair not one of six");
    a_square_self: assert property ( // RL5
        s.f0[`DOFD_F0_SQUARE] |-> mul_m == mul_n && mul_m[3:2] == 2'b01 && !err[0])
        else $error("square operands differ");
    a_awb_target: assert property ( // RL6
        result_store_back_target == dofd_pkg::DOFD_AWB_POST |-> aux[19:16] == `DOFD_W13 && aux[23:20] == 4'h2)
        else $error("write-back target wrong");
    a_faddr_range: assert property ( // RL8
        err[2] == (s.f1[15:13] != 3'h0))
        else $error("file address check late or wrong");
    a_lit_byte: assert property ( // RL9
        size != dofd_pkg::DOFD_SZ_BYTE |-> !err[3])
        else $error("constant refused outside byte mode");
    a_fdest_w0: assert property ( // RL7
        s.f0[`DOFD_F0_FDEST] |-> fdst == `DOFD_W0)
        else $error("file destination not W0");
    a_bit_select: assert property ( // RL11
        $onehot(bit_mask) && bit_mask[s.f0[`DOFD_F0_BITPOS]])
        else $error("bit select not one-hot");
    a_zero_flag: assert property ( // RL12
        cmd[`DOFD_CMD_ALU] && size == dofd_pkg::DOFD_SZ_WORD
        |=> s.aflg[`DOFD_FL_Z] == (s.res == 16'h0000) && s.aflg[`DOFD_FL_N] == s.res[15])
        else $error("zero or negative flag wrong");
    a_acc_select: assert property ( // RL14
        acc_go && s.f0[`DOFD_F0_ACCSEL] |=> $stable(acc[0]) && $stable(acc_clip[0]))
        else $error("unselected accumulator moved");
    a_acc_clip: assert property ( // RL13
        acc_clip[0] |-> acc[0][38:0] == {39{~acc[0][39]}})
        else $error("clip flag without clipped value");
    a_lone_nop: assert property ( // RL17
        wr_ok && adr == `DOFD_A_WORDIN && !s.pend && !wb_dat_i[`DOFD_WI_FIRST]
        && (&wb_sel_i[2:0]) && wb_dat_i[`DOFD_WI_HI8] == 8'h00 |=> s.nop ##1 !s.ack)
        else $error("lone second word not a no-op");
endmodule : dofd_top

// ---- sim/dofd_fetch_model.sv ----
// Purpose: fetch-side model that hands operand words to the block
// Assumes: one classic request at a time, registered ack
// Notes:   after time zero, signals move only by nba right after a rising edge
module dofd_fetch_model (
    // clock and answer
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    // request
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle bus at time zero
    initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    // one cycle; producer keeps address constants even, lsb zero
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, s, d};
        // hold until ack seen; only the bench timeout ends this
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        // released data goes to the inverse so stale values never match
        {cyc_o, stb_o, dat_o} <= {2'b00, ~d};
    endtask : xfer
endmodule : dofd_fetch_model

// ---- sim/dofd_top_tb_top.sv ----
// Purpose: register-level bench of the operand field decoder
// Assumes: ack one cycle after request, fields decode at once
// Notes:   expectations come from the field encodings only
`include "dofd_cfg.svh"
module dofd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel, v;
    logic [31:0] wd, rd, q, f, e;
    logic [3:0] stp [7] = '{4'h6, 4'h4, 4'h2, 4'h0, 4'hA, 4'hC, 4'hE};
    logic [7:0] mp [6] = '{8'h54, 8'h64, 8'h74, 8'h65, 8'h75, 8'h76};
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    always #25 clk_i = ~clk_i;
    dofd_top dofd_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack));
    dofd_fetch_model dofd_fetch_model_inst (.clk_i(clk_i), .ack_i(ack), .dat_i(rd),
        .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
    // verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    // compare one value
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        dofd_fetch_model_inst.xfer(1'b1, a, s, d, q);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        dofd_fetch_model_inst.xfer(1'b0, a, 4'hF, 32'h0000_0000, q);
    endtask : rdr
    // hang guard, well above the few hundred cycles needed
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        rdr(`DOFD_A_FIELDS0);
        chk("fields0", 32'h0000_0000, q);
        // every prefetch, dest, pair, square, write-back, size and mode code
        for (int i = 0; i < 16; i++) begin
            v = i[3:0];
            f = {v, v[2:0], v[0], 1'b0, v[0], v[1:0], v[1:0], v[1:0], v[3], v[2:0],
                 ~v[1:0], v[1:0], v, v};
            wr(`DOFD_A_FIELDS0, 4'hF, f);
            rdr(`DOFD_A_DECODE);
            if (i < 14) chk("x ptr", {stp[i % 7], i < 7 ? 4'h8 : 4'h9}, q[7:0]);
            if (i < 14) chk("y ptr", {stp[i % 7], i < 7 ? 4'hA : 4'hB}, q[15:8]);
            chk("dests", {2'b01, ~v[1:0], 2'b01, v[1:0]}, q[23:16]);
            if (v[3]) chk("square", {2'b01, v[1:0], 2'b01, v[1:0]}, q[31:24]);
            else if (v < 6) chk("pair", mp[v], q[31:24]);
            rdr(`DOFD_A_STATUS);
            chk("pf st", {v == 14, v != 15, v == 14, v != 15}, q[12:9]);
            if (!v[3]) chk("pair err", v[2:0] > 5, q[16]);
            chk("wb", {v[1:0] == 3, !v[3] && v[2:0] > 5, 1'b0, v[1:0]}, q[17:13]);
            chk("size", {v[0], 2'b00, v[2:0] == 7, v[1:0] == 3}, q[24:20]);
            rdr(`DOFD_A_AUX);
            e = {v[0] ? 4'h0 : 4'hF, v[1:0] == 2 ? 4'h2 : 4'h0, |v[1:0] ? 4'hD : 4'h0, 16'h0001 << v};
            chk("aux", e, {4'h0, q[27:0]});
        end
        $display("test field codes done");
        // address and constant limits at the boundary
        for (int i = 0; i < 3; i++) begin
            wr(`DOFD_A_FIELDS0, 4'hF, {10'h000, i < 2 ? 2'b01 : 2'b00, 20'h0_0000});
            wr(`DOFD_A_FIELDS1, 4'hF, {6'h00, i == 0 ? 10'h0FF : i == 1 ? 10'h100 : 10'h3FF,
                i == 1 ? 16'h2000 : 16'h1FFF});
            rdr(`DOFD_A_STATUS);
            chk("limits", {2{i == 1}}, q[19:18]);
        end
        $display("test limits done");
        // flags of word adds: carry to zero, then signed wrap
        wr(`DOFD_A_FIELDS0, 4'hF, 32'h0000_0000);
        wr(`DOFD_A_OPERAND, 4'hF, 32'h0001_FFFF);
        wr(`DOFD_A_COMMAND, 4'hF, 32'h0000_0001);
        rdr(`DOFD_A_STATUS);
        chk("flags1", 5'b10011, q[4:0]);
        wr(`DOFD_A_OPERAND, 4'hF, 32'h0001_7FFF);
        wr(`DOFD_A_COMMAND, 4'hF, 32'h0000_0001);
        rdr(`DOFD_A_STATUS);
        chk("flags2", 5'b01110, q[4:0]);
        rdr(`DOFD_A_RESULT);
        chk("result", 32'h0000_8000, {16'h0000, q[15:0]});
        // byte add: carry out, signed wrap, zero result
        wr(`DOFD_A_FIELDS0, 4'hF, 32'h0010_0000);
        wr(`DOFD_A_OPERAND, 4'hF, 32'h0080_0080);
        wr(`DOFD_A_COMMAND, 4'hF, 32'h0000_0001);
        rdr(`DOFD_A_STATUS);
        chk("flags3", 5'b11001, q[4:0]);
        // signed add into accumulator b only
        wr(`DOFD_A_FIELDS0, 4'hF, 32'h0080_0000);
        wr(`DOFD_A_OPERAND, 4'hF, 32'h0000_8000);
        wr(`DOFD_A_COMMAND, 4'hF, 32'h0000_0002);
        rdr(`DOFD_A_ACCB_LO);
        chk("acc b lo", 32'hFFFF_8000, q);
        rdr(`DOFD_A_ACCB_HI);
        chk("acc b hi", 32'h0000_00FF, {24'h00_0000, q[7:0]});
        rdr(`DOFD_A_ACCA_LO);
        chk("acc a lo", 32'h0000_0000, q);
        rdr(`DOFD_A_STATUS);
        chk("dsp flags", 4'h0, q[8:5]);
        $display("test arithmetic done");
        // lone second word, then a pair with a nonzero top byte
        wr(`DOFD_A_WORDIN, 4'h7, 32'h0000_0001);
        rdr(`DOFD_A_STATUS);
        chk("lone", 3'b001, q[25:23]);
        wr(`DOFD_A_WORDIN, 4'hF, 32'h0112_3456);
        rdr(`DOFD_A_STATUS);
        chk("pend", 1'b1, q[25]);
        wr(`DOFD_A_WORDIN, 4'h7, 32'h00FF_0000);
        rdr(`DOFD_A_STATUS);
        chk("second", 2'b01, {q[25], q[22]});
        rdr(`DOFD_A_PAIR_LO);
        chk("pair lo", 32'h56FF_0000, q);
        rdr(8'h3C);
        chk("unmapped", 32'h0000_0000, q);
        $display("test words done");
        test_done();
    end
endmodule : dofd_top_tb_top
